// ---- hw/ata_map.svh ----
// Register offsets, bit positions and codes of the command sequencer.
`ifndef ATA_MAP_SVH
`define ATA_MAP_SVH
// Register offsets on the four-bit register port.
`define ATA_OFS_FEAT 4'h1
`define ATA_OFS_SCNT 4'h2
`define ATA_OFS_SNUM 4'h3
`define ATA_OFS_CYLL 4'h4
`define ATA_OFS_CYLH 4'h5
`define ATA_OFS_DEVH 4'h6
`define ATA_OFS_CMD 4'h7
`define ATA_OFS_ALT 4'h8
`define ATA_OFS_ISTS 4'h9
`define ATA_OFS_IMSK 4'hA
`define ATA_OFS_CFG 4'hB
// Status and error bit positions.
`define ATA_STS_BSY 7
`define ATA_STS_RDY 6
`define ATA_STS_DRQ 3
`define ATA_STS_REL 2
`define ATA_STS_ERR 0
`define ATA_ERR_ABRT 2
// Interrupt status bits: completion, abort, bus release.
`define ATA_EVT_DONE 0
`define ATA_EVT_ABRT 1
`define ATA_EVT_REL 2
// Configuration bit: release interrupt enable.
`define ATA_CFG_RELIE 0
// Reset value of the release interrupt enable.
`define ATA_RST_RELIE 1'b0
// Data words in one sector.
`define ATA_WORDS_PER_SECTOR 256
// Opcodes and subcommands that the sequencer treats specially.
`define ATA_OP_NATMAX 8'hF8
`define ATA_OP_NATMAX_EXT 8'h27
`define ATA_OP_DCO 8'hB1
`define ATA_OP_VERIFY 8'h40
`define ATA_OP_VERIFY_NR 8'h41
`define ATA_OP_VERIFY_EXT 8'h42
`define ATA_OP_SETFEAT 8'hEF
`define ATA_FT_RELIE_ON 8'h5D
`define ATA_FT_RELIE_OFF 8'hDD
`define ATA_DCO_RESTORE 8'hC0
`define ATA_DCO_FREEZE 8'hC1
`define ATA_DCO_IDENT 8'hC2
`define ATA_DCO_SET 8'hC3
`endif

// ---- hw/ata_pkg.sv ----
// Types shared by the command sequencer and its opcode classifier.
package ata_pkg;
  // Protocol class of an opcode; zero means not recognised.
  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_PIO_IN = 3'h1,
    CLS_PIO_OUT = 3'h2,
    CLS_NODATA = 3'h3,
    CLS_DMA = 3'h4,
    CLS_QUEUED = 3'h5
  } ata_cls_e;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DECODE = 3'h1,
    ST_EXEC = 3'h2,
    ST_DMA = 3'h3,
    ST_QUEUE = 3'h4
  } ata_state_e;
  // Whole state of the classifier.
  typedef struct packed {
    ata_cls_e cls;
  } ata_dec_s;
  // Whole state of the sequencer.
  typedef struct packed {
    ata_state_e state;
    ata_cls_e cls;
    logic [7:0] opcode;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] devhd;
    logic bsy;
    logic drq;
    logic err;
    logic abrt;
    logic rel;
    logic intrq;
    logic rel_ie;
    logic dmarq;
    logic start;
    logic irq;
    logic [16:0] words;
    logic [2:0] sts;
    logic [2:0] msk;
    logic [7:0] rdata;
  } ata_seq_s;
endpackage

// ---- hw/ata_decode.sv ----
// Opcode classifier: maps an opcode and feature to a protocol class.
`timescale 1ns/10ps
`include "ata_map.svh"
module ata_decode
  import ata_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Opcode and feature to classify.
  input wire logic [7:0] opcode,
  input wire logic [7:0] feature,
  // Registered class.
  output ata_cls_e cls
);

  ata_dec_s dec_reg;
  ata_dec_s dec_next;

  ////////////////////////////////////////////////////////////////////////////
  // Class of an opcode; unknown codes give CLS_NONE.
  function automatic ata_cls_e classify(input logic [7:0] op,
                                        input logic [7:0] ft);
    ata_cls_e c;
    c = CLS_NONE;
    casez (op)
      `ATA_OP_NATMAX, `ATA_OP_NATMAX_EXT: c = CLS_NODATA; // RULE_13
      `ATA_OP_VERIFY, `ATA_OP_VERIFY_NR,
      `ATA_OP_VERIFY_EXT: c = CLS_NODATA; // RULE_15
      `ATA_OP_DCO:
      begin
        // One opcode, four operations chosen by the feature.
        case (ft) // RULE_14
          `ATA_DCO_RESTORE, `ATA_DCO_FREEZE: c = CLS_NODATA;
          `ATA_DCO_IDENT: c = CLS_PIO_IN;
          `ATA_DCO_SET: c = CLS_PIO_OUT;
          default: c = CLS_NONE;
        endcase
      end
      8'hB0:
      begin
        // Monitoring subcommands: two reads, a log read and a log write.
        case (ft)
          8'hD0, 8'hD1, 8'hD5: c = CLS_PIO_IN;
          8'hD6: c = CLS_PIO_OUT;
          default: c = CLS_NODATA;
        endcase
      end
      8'hE5, 8'h98, 8'h90, 8'hE7, 8'hEA, 8'hE3, 8'h97, 8'hE1, 8'h95,
      8'h91, 8'h00, 8'h1?, 8'h7?, 8'hF3, 8'hF5, 8'hEF, 8'hF9, 8'h37,
      8'hC6, 8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94: c = CLS_NODATA;
      8'hC8, 8'hC9, 8'h25, 8'hCA, 8'hCB, 8'h35: c = CLS_DMA;
      8'hC7, 8'h26, 8'hCC, 8'h36, 8'hA2: c = CLS_QUEUED;
      8'hEC, 8'hE4, 8'h22, 8'h23, 8'h2F, 8'hC4, 8'h29, 8'h20, 8'h21,
      8'h24: c = CLS_PIO_IN;
      8'h50, 8'hF6, 8'hF4, 8'hF1, 8'hF2, 8'hE8, 8'h3F, 8'h32, 8'h33,
      8'hC5, 8'h39, 8'h30, 8'h31, 8'h34: c = CLS_PIO_OUT;
      default: c = CLS_NONE;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next class is the decode of the current inputs.
  always_comb
  begin
    dec_next = dec_reg;
    dec_next.cls = classify(opcode, feature); // RULE_16
  end

  // Class register.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dec_reg <= '0;
    else
      dec_reg <= dec_next;
  end

  assign cls = dec_reg.cls;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the decode.
  a_native_max: assert property (@(posedge mclk) disable iff (rst) // RULE_13
    (opcode == `ATA_OP_NATMAX || opcode == `ATA_OP_NATMAX_EXT)
    |=> cls == CLS_NODATA)
    else $error("native max query not classed as non-data");
  a_verify_nodata: assert property (@(posedge mclk) disable iff (rst) // RULE_15
    (opcode inside {`ATA_OP_VERIFY, `ATA_OP_VERIFY_NR, `ATA_OP_VERIFY_EXT})
    |=> cls == CLS_NODATA)
    else $error("read verify not classed as non-data");
  a_dco_classes: assert property (@(posedge mclk) disable iff (rst) // RULE_14
    (opcode == `ATA_OP_DCO && feature == `ATA_DCO_IDENT) |=> cls == CLS_PIO_IN)
    else $error("configuration identify not classed as data-in");

endmodule

// ---- hw/ata_seq.sv ----
// Device-side command sequencer for non-data, DMA and queued DMA commands.
//
// Overview of operation
// RULE_01 - Host loads parameters before writing the opcode.
// RULE_02 - Non-data: BSY up, then down with interrupt.
// RULE_03 - Status read clears the pending interrupt.
// RULE_04 - Host programs its DMA channel before issuing.
// RULE_05 - DMARQ raised whenever device can move data.
// RULE_06 - DMA: exactly one interrupt, after all data.
// RULE_07 - Host resets DMA channel before reading status.
// RULE_08 - Host keeps one DMA mode per command.
// RULE_09 - Queued: BSY, then REL set or cleared, then not busy.
// RULE_10 - REL clear: data moves, then one interrupt.
// RULE_11 - Release interrupt only when release interrupt enabled.
// RULE_12 - Host then issues more or awaits service.
// RULE_13 - F8 and 27 are non-data max-address queries.
// RULE_14 - B1 accepted; feature picks its protocol class.
// RULE_15 - 40, 41, 42 verify as non-data commands.
// RULE_16 - Opcode class selects the handshake sequence.
// RULE_17 - Status read, reset or command write clears interrupt.
// RULE_18 - BSY or DRQ held until command completion.
// RULE_19 - Unknown opcode aborts with error and interrupt.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "ata_map.svh"
module ata_seq
  import ata_pkg::*;
#(
  parameter int WORDS_PER_SECTOR = `ATA_WORDS_PER_SECTOR
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Host link outputs.
  output logic ata_intrq,
  output logic dmarq,
  // Media side handshake.
  input wire logic proc_done,
  input wire logic xfer_ready,
  input wire logic queue_ready,
  input wire logic dma_word,
  output logic cmd_start,
  output ata_cls_e cmd_class,
  // Local interrupt.
  output logic irq
);

  // Whole sequencer state and its next value.
  ata_seq_s st_reg;
  ata_seq_s st_next;
  // Class from the classifier, valid in the decode state.
  ata_cls_e dec_cls;
  // Opcode write accepted while idle.
  logic cmd_acc;
  // Status register read, which clears the interrupt.
  logic sts_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte as the host sees it.
  function automatic logic [7:0] stat_byte(input ata_seq_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`ATA_STS_BSY] = s.bsy;
    b[`ATA_STS_RDY] = 1'b1;
    b[`ATA_STS_DRQ] = s.drq;
    b[`ATA_STS_REL] = s.rel;
    b[`ATA_STS_ERR] = s.err;
    return b;
  endfunction

  // Data words of a transfer; a zero count means 256 sectors.
  function automatic logic [16:0] word_total(input logic [7:0] cnt);
    return 17'({cnt == 8'h00, cnt} * WORDS_PER_SECTOR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode for the two side-effect accesses.
  assign cmd_acc = reg_wr && reg_addr == `ATA_OFS_CMD
                   && st_reg.state == ST_IDLE;
  assign sts_rd = reg_rd && reg_addr == `ATA_OFS_CMD;

  // The classifier decodes the opcode as it is written.
  ata_decode u_dec (
    .mclk(mclk),
    .rst(rst),
    .opcode(st_next.opcode),
    .feature(st_next.feat),
    .cls(dec_cls)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes, interrupt clears, sequencing, read data.
  always_comb
  begin
    logic [2:0] evt;
    logic [2:0] w1c;
    evt = 3'h0;
    w1c = 3'h0;
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.rdata = 8'h00;

    // Parameter writes only land while no command runs.
    if (reg_wr && st_reg.state == ST_IDLE)
    begin
      case (reg_addr)
        `ATA_OFS_FEAT: st_next.feat = reg_wdata;
        `ATA_OFS_SCNT: st_next.scnt = reg_wdata;
        `ATA_OFS_SNUM: st_next.snum = reg_wdata;
        `ATA_OFS_CYLL: st_next.cyl_lo = reg_wdata;
        `ATA_OFS_CYLH: st_next.cyl_hi = reg_wdata;
        `ATA_OFS_DEVH: st_next.devhd = reg_wdata;
        default: st_next.devhd = st_reg.devhd;
      endcase
    end

    // Local interrupt registers are writable at any time.
    if (reg_wr && reg_addr == `ATA_OFS_ISTS)
      w1c = reg_wdata[2:0];
    if (reg_wr && reg_addr == `ATA_OFS_IMSK)
      st_next.msk = reg_wdata[2:0];
    if (reg_wr && reg_addr == `ATA_OFS_CFG)
      st_next.rel_ie = reg_wdata[`ATA_CFG_RELIE];

    // A status read drops the host interrupt; later sets override.
    if (sts_rd)
      st_next.intrq = 1'b0; // RULE_03 RULE_17

    // Command sequencing.
    case (st_reg.state)
      ST_IDLE:
      begin
        // A command write starts a command and clears old results.
        if (cmd_acc)
        begin
          st_next.opcode = reg_wdata;
          st_next.bsy = 1'b1; // RULE_02
          st_next.intrq = 1'b0; // RULE_17
          st_next.err = 1'b0;
          st_next.abrt = 1'b0;
          st_next.rel = 1'b0;
          st_next.state = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        // The class picks the handshake that follows.
        st_next.cls = dec_cls; // RULE_16
        st_next.start = dec_cls != CLS_NONE;
        case (dec_cls)
          CLS_NONE:
          begin
            // Unknown opcode: abort at once.
            st_next.bsy = 1'b0; // RULE_19
            st_next.err = 1'b1; // RULE_19
            st_next.abrt = 1'b1;
            st_next.intrq = 1'b1;
            evt[`ATA_EVT_ABRT] = 1'b1;
            st_next.state = ST_IDLE;
          end
          CLS_DMA:
          begin
            // DRQ takes over from BSY for the data phase.
            st_next.bsy = 1'b0; // RULE_18
            st_next.drq = 1'b1;
            st_next.words = word_total(st_reg.scnt);
            st_next.state = ST_DMA;
          end
          CLS_QUEUED:
          begin
            // BSY stays up while REL reports readiness.
            st_next.rel = !queue_ready; // RULE_09
            st_next.state = ST_QUEUE;
          end
          default: st_next.state = ST_EXEC;
        endcase
      end
      ST_EXEC:
      begin
        // Non-data work runs outside; its end closes the command.
        if (proc_done)
        begin
          st_next.bsy = 1'b0; // RULE_02
          st_next.intrq = 1'b1; // RULE_02
          evt[`ATA_EVT_DONE] = 1'b1;
          st_next.state = ST_IDLE;
          // Set Features can switch the release interrupt.
          if (st_reg.opcode == `ATA_OP_SETFEAT)
          begin
            if (st_reg.feat == `ATA_FT_RELIE_ON)
              st_next.rel_ie = 1'b1;
            else if (st_reg.feat == `ATA_FT_RELIE_OFF)
              st_next.rel_ie = 1'b0;
          end
        end
      end
      ST_QUEUE:
      begin
        // Busy ends; a cleared REL goes on to the data phase.
        st_next.bsy = 1'b0; // RULE_09
        if (!st_reg.rel)
        begin
          st_next.drq = 1'b1; // RULE_10
          st_next.words = word_total(st_reg.scnt);
          st_next.state = ST_DMA;
        end
        else
        begin
          // Bus release; interrupt only when enabled.
          st_next.intrq = st_reg.rel_ie; // RULE_11
          evt[`ATA_EVT_REL] = 1'b1;
          st_next.state = ST_IDLE;
        end
      end
      ST_DMA:
      begin
        if (dma_word && st_reg.words == 17'h00001)
        begin
          // Last word moved: the one and only interrupt.
          st_next.drq = 1'b0;
          st_next.dmarq = 1'b0;
          st_next.intrq = 1'b1; // RULE_06 RULE_10
          evt[`ATA_EVT_DONE] = 1'b1;
          st_next.state = ST_IDLE;
        end
        else
        begin
          // Request whenever the media side can move data.
          st_next.dmarq = xfer_ready; // RULE_05
          if (dma_word)
            st_next.words = st_reg.words - 17'h00001;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase

    // Sticky local events: a new event wins over a clear.
    st_next.sts = (st_reg.sts & ~w1c) | evt;
    st_next.irq = |(st_next.sts & st_next.msk);

    // Read data for the cycle after the read strobe.
    if (reg_rd)
    begin
      case (reg_addr)
        `ATA_OFS_FEAT: st_next.rdata = {5'h00, st_reg.abrt, 2'h0};
        `ATA_OFS_SCNT: st_next.rdata = st_reg.scnt;
        `ATA_OFS_SNUM: st_next.rdata = st_reg.snum;
        `ATA_OFS_CYLL: st_next.rdata = st_reg.cyl_lo;
        `ATA_OFS_CYLH: st_next.rdata = st_reg.cyl_hi;
        `ATA_OFS_DEVH: st_next.rdata = st_reg.devhd;
        `ATA_OFS_CMD, `ATA_OFS_ALT: st_next.rdata = stat_byte(st_reg);
        `ATA_OFS_ISTS: st_next.rdata = {5'h00, st_reg.sts};
        `ATA_OFS_IMSK: st_next.rdata = {5'h00, st_reg.msk};
        `ATA_OFS_CFG: st_next.rdata = {7'h00, st_reg.rel_ie};
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset also clears the host interrupt.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0; // RULE_17
      st_reg.rel_ie <= `ATA_RST_RELIE;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register.
  assign reg_rdata = st_reg.rdata;
  assign ata_intrq = st_reg.intrq;
  assign dmarq = st_reg.dmarq;
  assign cmd_start = st_reg.start;
  assign cmd_class = st_reg.cls;
  assign irq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks and coverage of the sequencer.
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_cmd_busy: assert property ( // RULE_02
    cmd_acc |=> st_reg.bsy && !st_reg.intrq)
    else $error("command write did not raise busy");
  a_done_irq: assert property ( // RULE_02
    st_reg.state == ST_EXEC && proc_done
    |=> !st_reg.bsy && st_reg.intrq && st_reg.state == ST_IDLE)
    else $error("completion did not drop busy with interrupt");
  a_status_clear: assert property ( // RULE_03
    sts_rd && st_reg.state == ST_IDLE && !cmd_acc |=> !st_reg.intrq)
    else $error("status read left the interrupt pending");
  a_dmarq_ready: assert property ( // RULE_05
    st_reg.state == ST_DMA && xfer_ready && !dma_word |=> st_reg.dmarq)
    else $error("data request missing while ready");
  a_dma_one_irq: assert property ( // RULE_06
    $rose(st_reg.intrq) && $past(st_reg.state) == ST_DMA
    |-> $past(dma_word) && $past(st_reg.words) == 17'h00001)
    else $error("interrupt before the last data word");
  a_queue_order: assert property ( // RULE_09
    st_reg.state == ST_QUEUE |-> st_reg.bsy ##1 !st_reg.bsy
    && st_reg.rel == $past(st_reg.rel))
    else $error("queued issue order broken");
  a_release_irq: assert property ( // RULE_11
    st_reg.state == ST_QUEUE && st_reg.rel && !st_reg.rel_ie
    && !sts_rd |=> !st_reg.intrq)
    else $error("release interrupt while disabled");
  a_busy_or_drq: assert property ( // RULE_18
    st_reg.state != ST_IDLE |-> st_reg.bsy || st_reg.drq)
    else $error("neither busy nor data request during command");
  a_unknown_abort: assert property ( // RULE_19
    st_reg.state == ST_DECODE && dec_cls == CLS_NONE
    |=> !st_reg.bsy && st_reg.err && st_reg.abrt && st_reg.intrq)
    else $error("unknown opcode not aborted");

  c_nodata_done: cover property (
    st_reg.state == ST_EXEC ##1 st_reg.state == ST_IDLE);
  c_dma_done: cover property (
    st_reg.state == ST_DMA ##1 st_reg.state == ST_IDLE);
  c_release: cover property (st_reg.state == ST_QUEUE && st_reg.rel);
  c_abort: cover property (st_reg.state == ST_DECODE && dec_cls == CLS_NONE);

endmodule

// ---- dv/ata_dma_host.sv ----
// Behavioural host DMA channel and media responder for the sequencer bench.
`timescale 1ns/10ps
module ata_dma_host
  import ata_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Setup from the bench.
  input wire logic [16:0] words_prog,
  input wire logic [7:0] proc_lat,
  input wire logic stall,
  input wire logic slow,
  // Device side.
  input wire logic dmarq,
  input wire logic cmd_start,
  input wire ata_cls_e cmd_class,
  output logic proc_done,
  output logic xfer_ready,
  output logic dma_word,
  output logic [16:0] words_moved
);
  logic [16:0] left_reg; // Words still owed by the channel.
  logic [7:0] lat_reg; // Cycles until the media side finishes.
  logic busy_reg; // A command that moves no DMA data is running.
  logic media_cmd; // The accepted class waits for the media side.
  ////////////////////////////////////////////////////////////////////////////
  // Ready follows the stall control, so the bench can make the far side slow.
  assign xfer_ready = !stall;
  assign media_cmd = cmd_class inside {CLS_PIO_IN, CLS_PIO_OUT, CLS_NODATA};
  // Media completion pulse, and at most one DMA word per granted request.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      proc_done <= 1'b0;
      dma_word <= 1'b0;
      words_moved <= 17'h00000;
      left_reg <= 17'h00000;
      lat_reg <= 8'h00;
      busy_reg <= 1'b0;
    end
    else
    begin
      proc_done <= 1'b0;
      dma_word <= 1'b0;
      if (cmd_start && media_cmd)
      begin
        lat_reg <= proc_lat;
        busy_reg <= 1'b1;
      end
      else if (busy_reg && lat_reg == 8'h00)
      begin
        proc_done <= 1'b1;
        busy_reg <= 1'b0;
      end
      else if (busy_reg)
        lat_reg <= lat_reg - 8'h01;
      // The channel count is loaded before any data can move.
      if (cmd_start)
      begin
        left_reg <= words_prog;
        words_moved <= 17'h00000;
      end
      // One fixed word timing for the whole command; never beyond the count.
      else if (dmarq && !stall && left_reg != 0 && !(slow && dma_word))
      begin
        dma_word <= 1'b1;
        left_reg <= left_reg - 17'h00001;
        words_moved <= words_moved + 17'h00001;
      end
    end
  end
endmodule

// ---- dv/ata_command_protocol_sequencer_tb.sv ----
// Self-checking bench of the command sequencer with a host DMA model.
`timescale 1ns/10ps
`include "ata_map.svh"
module ata_command_protocol_sequencer_tb
  import ata_pkg::*;
();
  logic mclk, rst, reg_wr, reg_rd, ata_intrq, dmarq, proc_done, xfer_ready;
  logic queue_ready, dma_word, cmd_start, irq, stall, slow;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val, proc_lat;
  logic [16:0] words_prog, words_moved;
  ata_cls_e cmd_class;
  int n_fail, cmp_count, n_start, n_rise, n0;
  // Non-data table: opcode, feature and expected class.
  logic [7:0] nd_op [9] = '{8'h40, 8'h41, 8'h42, 8'hF8, 8'h27,
                            8'hB1, 8'hB1, 8'hB1, 8'hB1};
  logic [7:0] nd_ft [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'hC0, 8'hC1, 8'hC2, 8'hC3};
  ata_cls_e nd_cl [9] = '{CLS_NODATA, CLS_NODATA, CLS_NODATA, CLS_NODATA,
                          CLS_NODATA, CLS_NODATA, CLS_NODATA, CLS_PIO_IN,
                          CLS_PIO_OUT};
  logic [16:0] dm_words [3] = '{17'h00004, 17'h00008, 17'h00400};
  logic [7:0] dm_cnt [3] = '{8'h01, 8'h02, 8'h00};
  ////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;
  // Counts accepted commands, and host interrupt rises as they happen.
  always @(posedge mclk)
  begin
    if (cmd_start === 1'b1) n_start++;
  end
  always @(posedge ata_intrq) n_rise++;
  ata_seq #(.WORDS_PER_SECTOR(4)) dut (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ata_intrq(ata_intrq),
    .dmarq(dmarq), .proc_done(proc_done), .xfer_ready(xfer_ready),
    .queue_ready(queue_ready), .dma_word(dma_word), .cmd_start(cmd_start),
    .cmd_class(cmd_class), .irq(irq));
  ata_dma_host host (.mclk(mclk), .rst(rst), .words_prog(words_prog),
    .proc_lat(proc_lat), .stall(stall), .slow(slow), .dmarq(dmarq),
    .cmd_start(cmd_start), .cmd_class(cmd_class), .proc_done(proc_done),
    .xfer_ready(xfer_ready), .dma_word(dma_word),
    .words_moved(words_moved));
  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d.", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [16:0] seen,
                     input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data is taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Waits a bounded time for the host interrupt.
  task automatic wait_int();
    int k;
    k = 0;
    while (ata_intrq !== 1'b1 && k < 3000)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 3000)
    begin
      chk("intrq_wait", 17'h0, 17'h1);
      stop_test();
    end
  endtask
  // Parameters first, then the opcode.
  task automatic issue(input logic [7:0] op, input logic [7:0] ft,
                       input logic [7:0] sc);
    wr(`ATA_OFS_FEAT, ft);
    wr(`ATA_OFS_SCNT, sc);
    wr(`ATA_OFS_CMD, op);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped read.
  task automatic t_reset();
    rd(`ATA_OFS_CMD, rd_val);
    chk("status", rd_val, 8'h40);
    rd(`ATA_OFS_CFG, rd_val);
    chk("config", rd_val, 8'h00);
    rd(4'hF, rd_val);
    chk("unmapped", rd_val, 8'h00);
    chk("intrq", ata_intrq, 1'b0);
    $display("Test reset finished.");
  endtask
  // Every non-data and device-configuration opcode of the table.
  task automatic t_nodata();
    for (int i = 0; i < 9; i++)
    begin
      n0 = n_start;
      issue(nd_op[i], nd_ft[i], 8'h00);
      rd(`ATA_OFS_ALT, rd_val);
      chk("busy", rd_val, 8'hC0);
      chk("early_intrq", ata_intrq, 1'b0);
      chk("class", cmd_class, nd_cl[i]);
      wait_int();
      chk("starts", 17'(n_start - n0), 17'h1);
      rd(`ATA_OFS_ALT, rd_val);
      chk("alt_intrq", ata_intrq, 1'b1);
      rd(`ATA_OFS_CMD, rd_val);
      chk("done", rd_val, 8'h40);
      chk("cleared", ata_intrq, 1'b0);
    end
    $display("Test non-data finished.");
  endtask
  // Feature that the configuration opcode does not know.
  task automatic t_abort();
    wr(`ATA_OFS_ISTS, 8'hFF);
    issue(8'hB1, 8'h55, 8'h00);
    wait_int();
    chk("class", cmd_class, CLS_NONE);
    rd(`ATA_OFS_FEAT, rd_val);
    chk("error", rd_val, 8'h04);
    rd(`ATA_OFS_ISTS, rd_val);
    chk("events", rd_val, 8'h02);
    rd(`ATA_OFS_CMD, rd_val);
    chk("status", rd_val, 8'h41);
    $display("Test abort finished.");
  endtask
  // Command write while busy, command write and reset clearing.
  task automatic t_busy();
    proc_lat <= 8'd20;
    n0 = n_start;
    issue(8'h40, 8'h00, 8'h00);
    wr(`ATA_OFS_CMD, 8'h42);
    wait_int();
    chk("starts", 17'(n_start - n0), 17'h1);
    wr(`ATA_OFS_CMD, 8'h40);
    #1;
    chk("cmd_clear", ata_intrq, 1'b0);
    wait_int();
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("rst_clear", ata_intrq, 1'b0);
    proc_lat <= 8'd6;
    $display("Test busy finished.");
  endtask
  // DMA with one, two and 256 sectors, the far side stalled at first.
  task automatic t_dma();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      words_prog <= dm_words[i];
      stall <= 1'b1;
      slow <= i[0];
      n0 = n_rise;
      issue(8'hC8, 8'h00, dm_cnt[i]);
      repeat (4) @(posedge mclk);
      #1;
      chk("dmarq_stall", dmarq, 1'b0);
      rd(`ATA_OFS_ALT, rd_val);
      chk("drq", rd_val, 8'h48);
      @(posedge mclk);
      stall <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("dmarq", dmarq, 1'b1);
      wait_int();
      chk("words", words_moved, dm_words[i]);
      chk("irqs", 17'(n_rise - n0), 17'h1);
      chk("dmarq_end", dmarq, 1'b0);
      words_prog <= 17'h00000;
      rd(`ATA_OFS_CMD, rd_val);
      chk("status", rd_val, 8'h40);
    end
    $display("Test DMA finished.");
  endtask
  // Queued: release without and with interrupt, then a data phase.
  task automatic t_queue();
    wr(`ATA_OFS_CFG, 8'h00);
    n0 = n_rise;
    issue(8'hCC, 8'h00, 8'h01);
    repeat (8) @(posedge mclk);
    rd(`ATA_OFS_ALT, rd_val);
    chk("release", rd_val, 8'h44);
    chk("class", cmd_class, CLS_QUEUED);
    chk("no_irq", 17'(n_rise - n0), 17'h0);
    wr(`ATA_OFS_CFG, 8'h01);
    issue(8'hCC, 8'h00, 8'h01);
    wait_int();
    rd(`ATA_OFS_CMD, rd_val);
    chk("release_ie", rd_val, 8'h44);
    @(posedge mclk);
    queue_ready <= 1'b1;
    words_prog <= 17'h00004;
    issue(8'hCC, 8'h00, 8'h01);
    wait_int();
    chk("words", words_moved, 17'h00004);
    rd(`ATA_OFS_CMD, rd_val);
    chk("status", rd_val, 8'h40);
    issue(8'hEF, 8'hDD, 8'h00);
    wait_int();
    rd(`ATA_OFS_CMD, rd_val);
    rd(`ATA_OFS_CFG, rd_val);
    chk("relie_off", rd_val, 8'h00);
    issue(8'hEF, 8'h5D, 8'h00);
    wait_int();
    rd(`ATA_OFS_CMD, rd_val);
    rd(`ATA_OFS_CFG, rd_val);
    chk("relie_on", rd_val, 8'h01);
    $display("Test queued finished.");
  endtask
  // Local interrupt: raise, mask and clear.
  task automatic t_irq();
    wr(`ATA_OFS_ISTS, 8'hFF);
    wr(`ATA_OFS_IMSK, 8'h00);
    issue(8'h40, 8'h00, 8'h00);
    wait_int();
    rd(`ATA_OFS_CMD, rd_val);
    rd(`ATA_OFS_ISTS, rd_val);
    chk("ists", rd_val, 8'h01);
    chk("irq_masked", irq, 1'b0);
    wr(`ATA_OFS_IMSK, 8'h01);
    @(posedge mclk);
    #1;
    chk("irq_on", irq, 1'b1);
    wr(`ATA_OFS_ISTS, 8'h01);
    @(posedge mclk);
    #1;
    chk("irq_clear", irq, 1'b0);
    rd(`ATA_OFS_ISTS, rd_val);
    chk("ists_clear", rd_val, 8'h00);
    $display("Test interrupt finished.");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, stall, slow, queue_ready} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    proc_lat = 8'd6;
    words_prog = 17'h00000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_nodata();
    t_abort();
    t_busy();
    t_dma();
    t_queue();
    t_irq();
    stop_test();
  end
endmodule
